// ---- core/cdl_loader.sv ----
// configuration download, update control, state fetch and fault latch
// assumes bus engine, nv array and detectors share clock_in; supply level
// comparator is asynchronous
//
// Contract
// - one fault bit per input, set when enabled
// - fault bits readable over the bus
// - state word gates fault latching
// - status shows uv, ov, adc limit
// - status reads are live, unlatched
// - each config byte is a latch pair
// - download starts above supply lockout level
// - fill all first sides, then copy together
// - wait 0.5 ms before first state fetch
// - nack all access until download done
// - transparent bit: both sides follow writes
// - staged bit: only first side written
// - commit bit gives one copy pulse
// - nv writes leave operating config intact
// - reload restores latches from nv
// - enabled erase sets page to ones
// - disabled erase is ignored
// - 512-byte state store, slot 63 reserved
// - fetch next state word on exit
// - state words only live in nv
// - reload trigger bit reloads pages 0-6
`timescale 1ns/100ps
module cdl_loader #(
  parameter int SE_WAIT_CYCLES = cdl_pkg::SE_WAIT_CYC
) (
  input  logic                              clock_in,
  input  logic                              rst_b_in,
  input  logic                              supply_ok_in,
  input  logic                              host_req_in,
  input  cdl_pkg::cdl_host_req_t            host_cmd_in,
  output logic                              host_ack_out,
  output logic                              host_nack_out,
  output logic [7:0]                        host_rdata_out,
  output logic                              nv_req_out,
  output cdl_pkg::cdl_nv_req_t              nv_cmd_out,
  input  logic                              nv_done_in,
  input  logic [7:0]                        nv_rdata_in,
  input  logic [9:0]                        fault_in,
  input  cdl_pkg::cdl_status_t              status_in,
  input  logic                              se_advance_in,
  input  logic [5:0]                        se_next_idx_in,
  output logic [63:0]                       se_word_out,
  output logic [5:0]                        se_idx_out,
  output logic                              se_load_out,
  output logic                              boot_done_out,
  output logic [cdl_pkg::CFG_BYTES*8-1:0]   cfg_image_out
);

  function automatic logic [15:0] nv_at(input logic [15:0] base,
                                        input logic [15:0] ofs);
    nv_at = 16'(base + ofs);
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic                                       sup_s1, sup_s2, sup_s3, sup_ok;
  cdl_pkg::cdl_state_t                        state, next_state;
  logic [cdl_pkg::CFG_BYTES-1:0][7:0]         latch_a, latch_b;
  logic [7:0]                                 upd, dl_idx;
  logic [15:0]                                wait_cnt;
  logic [2:0]                                 se_byte;
  logic [63:0]                                se_asm;
  logic [5:0]                                 se_pend_idx;
  logic                                       se_pend, reload_pend, booted;
  logic                                       commit_pulse;
  logic [9:0]                                 fault_latch;
  cdl_pkg::cdl_nv_req_t                       host_nv;
  logic                                       open, take, nv_go, reg_go;
  logic                                       is_nv, is_erase, is_cfg, wr;
  logic                                       ram_wr, fault_clr;
  logic [7:0]                                 ram_idx, rd_mux;

  assign wr        = host_cmd_in.write;
  assign open      = (state == cdl_pkg::ST_IDLE) ||
                     (state == cdl_pkg::ST_SE_WAIT);
  assign take      = host_req_in && open;
  assign is_nv     = host_cmd_in.addr >= cdl_pkg::NV_LO &&
                     host_cmd_in.addr <= cdl_pkg::NV_HI;
  assign is_erase  = hit(host_cmd_in.addr, cdl_pkg::ERASE_OFF);
  assign is_cfg    = host_cmd_in.addr < 16'(cdl_pkg::CFG_BYTES);
  assign nv_go     = take && state == cdl_pkg::ST_IDLE &&
                     (is_nv || (is_erase && wr &&
                      upd[cdl_pkg::UPD_ERASE_EN]));
  assign reg_go    = take && !is_nv && (is_cfg ||
                     host_cmd_in.addr <= cdl_pkg::ADC_OFF);
  assign ram_idx   = host_cmd_in.addr[7:0];
  assign ram_wr    = reg_go && wr && is_cfg &&
                     !hit(host_cmd_in.addr, cdl_pkg::UPD_OFF) &&
                     !hit(host_cmd_in.addr, cdl_pkg::RELOAD_OFF) &&
                     !is_erase;
  assign fault_clr = reg_go && wr &&
                     (hit(host_cmd_in.addr, cdl_pkg::FAULT_A_OFF) ||
                      hit(host_cmd_in.addr, cdl_pkg::FAULT_B_OFF));

  ////////////////////////////////////////////////////////////////////////////
  // supply level: three stages, change taken when last two agree
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
      sup_s3 <= 1'b0;
      sup_ok <= 1'b0;
    end else begin
      sup_s1 <= supply_ok_in;
      sup_s2 <= sup_s1;
      sup_s3 <= sup_s2;
      if (sup_s2 == sup_s3) begin
        sup_ok <= sup_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      cdl_pkg::ST_LOCK: begin
        if (sup_ok) next_state = cdl_pkg::ST_DL_RD;
      end
      cdl_pkg::ST_DL_RD: begin
        if (nv_done_in && dl_idx == 8'(cdl_pkg::CFG_BYTES - 1)) begin
          next_state = cdl_pkg::ST_DL_XFER;
        end
      end
      cdl_pkg::ST_DL_XFER: begin
        next_state = booted ? cdl_pkg::ST_IDLE : cdl_pkg::ST_SE_WAIT;
      end
      cdl_pkg::ST_SE_WAIT: begin
        if (wait_cnt == 16'(SE_WAIT_CYCLES - 1)) begin
          next_state = cdl_pkg::ST_SE_RD;
        end
      end
      cdl_pkg::ST_SE_RD: begin
        if (nv_done_in && se_byte == 3'h7) next_state = cdl_pkg::ST_IDLE;
      end
      cdl_pkg::ST_IDLE: begin
        if (nv_go) next_state = cdl_pkg::ST_HOST_NV;
        else if (reload_pend) next_state = cdl_pkg::ST_DL_RD;
        else if (se_pend) next_state = cdl_pkg::ST_SE_RD;
      end
      cdl_pkg::ST_HOST_NV: begin
        if (nv_done_in) next_state = cdl_pkg::ST_IDLE;
      end
      default: next_state = cdl_pkg::ST_LOCK;
    endcase
    if (!sup_ok) next_state = cdl_pkg::ST_LOCK;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) state <= cdl_pkg::ST_LOCK;
    else state <= next_state;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dl_idx   <= 8'h00;
      wait_cnt <= 16'h0000;
      booted   <= 1'b0;
    end else begin
      if (state != cdl_pkg::ST_DL_RD) dl_idx <= 8'h00;
      else if (nv_done_in) dl_idx <= 8'(dl_idx + 8'h01);
      if (state != cdl_pkg::ST_SE_WAIT) wait_cnt <= 16'h0000;
      else wait_cnt <= 16'(wait_cnt + 16'h0001);
      if (state == cdl_pkg::ST_LOCK) booted <= 1'b0;
      else if (state == cdl_pkg::ST_DL_XFER) booted <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch pairs: first side takes download and host bytes
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_a <= '0;
    end else if (state == cdl_pkg::ST_DL_RD && nv_done_in) begin
      latch_a[dl_idx] <= nv_rdata_in;
    end else if (ram_wr) begin
      latch_a[ram_idx] <= host_cmd_in.wdata;
    end
  end

  // second side drives function: copy all at once or follow writes
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_b <= '0;
    end else begin
      if (state == cdl_pkg::ST_DL_XFER || commit_pulse) begin
        latch_b <= latch_a;
      end
      if (ram_wr && upd[cdl_pkg::UPD_TRANSP]) begin
        latch_b[ram_idx] <= host_cmd_in.wdata;
      end
    end
  end
  assign cfg_image_out = latch_b;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upd          <= cdl_pkg::UPD_RESET;
      commit_pulse <= 1'b0;
      reload_pend  <= 1'b0;
    end else begin
      commit_pulse <= reg_go && wr && hit(host_cmd_in.addr, cdl_pkg::UPD_OFF)
                      && host_cmd_in.wdata[cdl_pkg::UPD_COMMIT];
      if (reg_go && wr && hit(host_cmd_in.addr, cdl_pkg::UPD_OFF)) begin
        upd <= host_cmd_in.wdata & ~(8'h01 << cdl_pkg::UPD_COMMIT);
      end
      if (reg_go && wr && hit(host_cmd_in.addr, cdl_pkg::RELOAD_OFF) &&
          host_cmd_in.wdata[cdl_pkg::RELOAD_BIT]) begin
        reload_pend <= 1'b1;
      end else if (next_state == cdl_pkg::ST_DL_RD) begin
        reload_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state word fetch, eight bytes low first, nothing cached
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      se_byte     <= 3'h0;
      se_asm      <= cdl_pkg::SE_WORD_RESET;
      se_word_out <= cdl_pkg::SE_WORD_RESET;
      se_idx_out  <= 6'h00;
      se_load_out <= 1'b0;
      se_pend     <= 1'b0;
      se_pend_idx <= 6'h00;
    end else begin
      se_load_out <= 1'b0;
      if (se_advance_in && se_next_idx_in != cdl_pkg::SE_RSVD_IDX) begin
        se_pend     <= 1'b1;
        se_pend_idx <= se_next_idx_in;
      end else if (state == cdl_pkg::ST_IDLE &&
                   next_state == cdl_pkg::ST_SE_RD) begin
        se_pend    <= 1'b0;
        se_idx_out <= se_pend_idx;
      end
      if (state == cdl_pkg::ST_SE_RD && nv_done_in) begin
        se_byte <= 3'(se_byte + 3'h1);
        se_asm  <= {nv_rdata_in, se_asm[63:8]};
        if (se_byte == 3'h7) begin
          se_word_out <= {nv_rdata_in, se_asm[63:8]};
          se_load_out <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nv port shared by download, state fetch and host access
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      host_nv <= '{cmd: cdl_pkg::NV_RD, addr: 16'h0000, wdata: 8'h00};
    end else if (nv_go) begin
      host_nv.wdata <= host_cmd_in.wdata;
      if (is_erase) begin
        host_nv.cmd  <= cdl_pkg::NV_ERASE;
        host_nv.addr <= nv_at(cdl_pkg::NV_LO,
                              {6'h00, host_cmd_in.wdata[4:0], 5'h00});
      end else begin
        host_nv.cmd  <= wr ? cdl_pkg::NV_WR : cdl_pkg::NV_RD;
        host_nv.addr <= host_cmd_in.addr;
      end
    end
  end

  always_comb begin
    nv_req_out = 1'b0;
    nv_cmd_out = host_nv;
    case (state)
      cdl_pkg::ST_DL_RD: begin
        nv_req_out = 1'b1;
        nv_cmd_out = '{cmd: cdl_pkg::NV_RD, wdata: 8'h00,
                       addr: nv_at(cdl_pkg::CFG_NV_BASE, {8'h00, dl_idx})};
      end
      cdl_pkg::ST_SE_RD: begin
        nv_req_out = 1'b1;
        nv_cmd_out = '{cmd: cdl_pkg::NV_RD, wdata: 8'h00,
                       addr: nv_at(cdl_pkg::SE_NV_BASE,
                                   {7'h00, se_idx_out, se_byte})};
      end
      cdl_pkg::ST_HOST_NV: nv_req_out = 1'b1;
      default: nv_req_out = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault latch: set wins over clear, held otherwise
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_latch <= 10'h000;
    end else begin
      fault_latch <= (fault_latch & ~({10{fault_clr}} &
        (hit(host_cmd_in.addr, cdl_pkg::FAULT_A_OFF) ?
         {2'b00, host_cmd_in.wdata} : {host_cmd_in.wdata[1:0], 8'h00})))
        | (fault_in & {10{se_word_out[cdl_pkg::SE_LATCH_BIT]}});
    end
  end

  always_comb begin
    case (host_cmd_in.addr)
      cdl_pkg::UPD_OFF:     rd_mux = upd;
      cdl_pkg::RELOAD_OFF:  rd_mux = {7'h00, reload_pend};
      cdl_pkg::FAULT_A_OFF: rd_mux = fault_latch[7:0];
      cdl_pkg::FAULT_B_OFF: rd_mux = {6'h00, fault_latch[9:8]};
      cdl_pkg::UV_LO_OFF:   rd_mux = status_in.uv[7:0];
      cdl_pkg::UV_HI_OFF:   rd_mux = {6'h00, status_in.uv[9:8]};
      cdl_pkg::OV_LO_OFF:   rd_mux = status_in.ov[7:0];
      cdl_pkg::OV_HI_OFF:   rd_mux = {6'h00, status_in.ov[9:8]};
      cdl_pkg::ADC_OFF:     rd_mux = status_in.adc;
      default:              rd_mux = is_cfg ? latch_a[ram_idx] : 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      host_ack_out   <= 1'b0;
      host_nack_out  <= 1'b0;
      host_rdata_out <= 8'h00;
    end else begin
      host_ack_out  <= (reg_go && !nv_go) ||
                       (state == cdl_pkg::ST_HOST_NV && nv_done_in);
      host_nack_out <= host_req_in && !nv_go && !reg_go;
      if (reg_go && !wr) host_rdata_out <= rd_mux;
      else if (state == cdl_pkg::ST_HOST_NV && nv_done_in &&
               host_nv.cmd == cdl_pkg::NV_RD) host_rdata_out <= nv_rdata_in;
    end
  end
  assign boot_done_out = booted;

  ////////////////////////////////////////////////////////////////////////////
  AST_NACK_BEFORE_BOOT: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) host_req_in && !booted |=> host_nack_out)
    else $error("access before download end not refused");
  AST_FAULT_SET: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) se_word_out[cdl_pkg::SE_LATCH_BIT] |=>
    ((fault_latch & $past(fault_in)) == $past(fault_in)))
    else $error("enabled fault not latched");
  AST_FAULT_GATED: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) !se_word_out[cdl_pkg::SE_LATCH_BIT] && !fault_clr
    |=> fault_latch == $past(fault_latch))
    else $error("fault latched while disabled");
  AST_STAGED: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) ram_wr && !upd[cdl_pkg::UPD_TRANSP] &&
    !commit_pulse |=> cfg_image_out == $past(cfg_image_out))
    else $error("staged write reached operating side");
  AST_TRANSP: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) ram_wr && upd[cdl_pkg::UPD_TRANSP] |=>
    latch_b[$past(ram_idx)] == $past(host_cmd_in.wdata))
    else $error("transparent write not applied");
  AST_COMMIT: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) commit_pulse |=> !commit_pulse &&
    cfg_image_out == $past(latch_a))
    else $error("commit pulse wrong");
  AST_XFER: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) state == cdl_pkg::ST_DL_XFER |=>
    cfg_image_out == $past(latch_a))
    else $error("first sides not copied together");
  AST_SE_WAIT: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) state == cdl_pkg::ST_SE_WAIT &&
    next_state == cdl_pkg::ST_SE_RD |-> wait_cnt == 16'(SE_WAIT_CYCLES - 1))
    else $error("state fetch before wait ended");
  AST_ERASE_OFF: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) take && is_erase && wr &&
    !upd[cdl_pkg::UPD_ERASE_EN] |=> !nv_req_out && host_ack_out)
    else $error("disabled erase was issued");
  AST_ERASE_ON: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) nv_go && is_erase |=> nv_req_out &&
    nv_cmd_out.cmd == cdl_pkg::NV_ERASE)
    else $error("enabled erase not issued");
endmodule

// ---- core/cdl_pkg.sv ----
// constants and carrier types for the configuration loader
// assumes one 10 MHz system clock shared with the bus engine and nv array
package cdl_pkg;
  localparam int          CLK_NS        = 32'h0000_0064;
  localparam int          SE_WAIT_NS    = 32'h0007_A120;
  localparam int          SE_WAIT_CYC   = (SE_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CFG_BYTES     = 32'h0000_00E0;
  localparam logic [15:0] NV_LO         = 16'hF800;
  localparam logic [15:0] NV_HI         = 16'hFBFF;
  localparam logic [15:0] CFG_NV_BASE   = 16'hF800;
  localparam logic [15:0] SE_NV_BASE    = 16'hFA00;
  localparam logic [15:0] UPD_OFF       = 16'h00D7;
  localparam logic [15:0] RELOAD_OFF    = 16'h00D8;
  localparam logic [15:0] ERASE_OFF     = 16'h00D9;
  localparam logic [15:0] FAULT_A_OFF   = 16'h00E0;
  localparam logic [15:0] FAULT_B_OFF   = 16'h00E1;
  localparam logic [15:0] UV_LO_OFF     = 16'h00E2;
  localparam logic [15:0] UV_HI_OFF     = 16'h00E3;
  localparam logic [15:0] OV_LO_OFF     = 16'h00E4;
  localparam logic [15:0] OV_HI_OFF     = 16'h00E5;
  localparam logic [15:0] ADC_OFF       = 16'h00E6;
  localparam int          UPD_TRANSP    = 32'h0000_0000;
  localparam int          UPD_COMMIT    = 32'h0000_0001;
  localparam int          UPD_ERASE_EN  = 32'h0000_0002;
  localparam logic [7:0]  UPD_RESET     = 8'h01;
  localparam int          RELOAD_BIT    = 32'h0000_0000;
  localparam int          SE_LATCH_BIT  = 32'h0000_003F;
  localparam logic [5:0]  SE_RSVD_IDX   = 6'h3F;
  localparam logic [63:0] SE_WORD_RESET = 64'h0000_0000_0000_0000;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cdl_host_req_t;

  typedef enum logic [1:0] {NV_RD, NV_WR, NV_ERASE} cdl_nv_cmd_t;

  typedef struct packed {
    cdl_nv_cmd_t cmd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cdl_nv_req_t;

  typedef struct packed {
    logic [9:0] uv;
    logic [9:0] ov;
    logic [7:0] adc;
  } cdl_status_t;

  typedef enum logic [2:0] {
    ST_LOCK, ST_DL_RD, ST_DL_XFER, ST_SE_WAIT, ST_SE_RD, ST_IDLE, ST_HOST_NV
  } cdl_state_t;
endpackage

// ---- dv/cdl_nv_model.sv ----
// nonvolatile array model facing the configuration loader nv port
// assumes the shared system clock; slow_in adds three cycles a request
`timescale 1ns/100ps
module cdl_nv_model (
  input  logic                 clock_in,
  input  logic                 slow_in,
  input  logic                 nv_req_in,
  input  cdl_pkg::cdl_nv_req_t nv_cmd_in,
  output logic                 nv_done_out,
  output logic [7:0]           nv_rdata_out
);
  logic [7:0] mem [0:1023];
  int         wait_cnt;

  initial begin
    nv_done_out  = 1'b0;
    nv_rdata_out = 8'h00;
    wait_cnt     = 0;
    for (int i = 0; i < 1024; i++) begin
      if (i < 512) mem[i] = 8'h5A ^ i[7:0];
      else if (i[2:0] != 3'h7) mem[i] = {i[6:3], 1'b0, i[2:0]};
      else mem[i] = (i[8:3] == 6'h01) ? 8'h00 : 8'h80;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data line toggles whenever no answer is being given
  always @(posedge clock_in) begin
    nv_done_out  <= 1'b0;
    nv_rdata_out <= ~nv_rdata_out;
    if (nv_req_in && !nv_done_out) begin
      if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end else begin
        wait_cnt    <= slow_in ? 3 : 0;
        nv_done_out <= 1'b1;
        case (nv_cmd_in.cmd)
          cdl_pkg::NV_RD: nv_rdata_out <= mem[nv_cmd_in.addr[9:0]];
          cdl_pkg::NV_WR: begin
            mem[nv_cmd_in.addr[9:0]] <=
              mem[nv_cmd_in.addr[9:0]] & nv_cmd_in.wdata;
          end
          default: begin
            for (int k = 0; k < 32; k++)
              mem[{nv_cmd_in.addr[9:5], k[4:0]}] <= 8'hFF;
          end
        endcase
      end
    end
  end
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the configuration loader
// assumes the nv model answers requests; host accesses are one-cycle pulses
`timescale 1ns/100ps
module testbench;
  localparam int SE_W = 5;
  logic                            clock_in = 1'b0;
  logic                            rst_b_in = 1'b0;
  logic                            supply_ok_in = 1'b0;
  logic                            host_req_in = 1'b0;
  cdl_pkg::cdl_host_req_t          host_cmd_in = '0;
  logic                            host_ack_out;
  logic                            host_nack_out;
  logic [7:0]                      host_rdata_out;
  logic                            nv_req_out;
  cdl_pkg::cdl_nv_req_t            nv_cmd_out;
  logic                            nv_done_in;
  logic [7:0]                      nv_rdata_in;
  logic [9:0]                      fault_in = '0;
  cdl_pkg::cdl_status_t            status_in = '0;
  logic                            se_advance_in = 1'b0;
  logic [5:0]                      se_next_idx_in = '0;
  logic [63:0]                     se_word_out;
  logic [5:0]                      se_idx_out;
  logic                            se_load_out;
  logic                            boot_done_out;
  logic [cdl_pkg::CFG_BYTES*8-1:0] cfg_image_out;
  logic                            slow = 1'b1;
  logic [7:0]                      rd;
  logic                            ok;
  int                              n;
  int                              n_errors = 0;
  int                              check_count = 0;

  always #50 clock_in = ~clock_in;

  cdl_loader #(.SE_WAIT_CYCLES(SE_W)) i_cdl_loader (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .supply_ok_in(supply_ok_in),
    .host_req_in(host_req_in), .host_cmd_in(host_cmd_in),
    .host_ack_out(host_ack_out), .host_nack_out(host_nack_out),
    .host_rdata_out(host_rdata_out), .nv_req_out(nv_req_out),
    .nv_cmd_out(nv_cmd_out), .nv_done_in(nv_done_in),
    .nv_rdata_in(nv_rdata_in), .fault_in(fault_in), .status_in(status_in),
    .se_advance_in(se_advance_in), .se_next_idx_in(se_next_idx_in),
    .se_word_out(se_word_out), .se_idx_out(se_idx_out),
    .se_load_out(se_load_out), .boot_done_out(boot_done_out),
    .cfg_image_out(cfg_image_out));

  cdl_nv_model i_cdl_nv_model (
    .clock_in(clock_in), .slow_in(slow), .nv_req_in(nv_req_out),
    .nv_cmd_in(nv_cmd_out), .nv_done_out(nv_done_in),
    .nv_rdata_out(nv_rdata_in));

  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                     input string msg);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t %s: got %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [15:0] a,
                     input logic [7:0] d);
    int k;
    host_req_in <= 1'b1;
    host_cmd_in <= '{wr, a, d};
    @(posedge clock_in);
    host_req_in <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge clock_in);
      if (host_ack_out === 1'b1 || host_nack_out === 1'b1) break;
    end
    ok = (host_ack_out === 1'b1);
    rd = host_rdata_out;
    if (k == 200) chk(1, 0, "no answer");
  endtask

  task automatic rdx(input logic [15:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(ok, 1'b1, "read refused");
    chk(rd, exp, "read data");
  endtask

  task automatic adv(input logic [5:0] idx);
    se_advance_in  <= 1'b1;
    se_next_idx_in <= idx;
    @(posedge clock_in);
    se_advance_in <= 1'b0;
    for (n = 0; n < 40 && se_load_out !== 1'b1; n++) @(posedge clock_in);
  endtask

  task automatic pulse_fault(input logic [9:0] f);
    fault_in <= f;
    @(posedge clock_in);
    fault_in <= '0;
    @(posedge clock_in);
  endtask

  function automatic logic [7:0] img(input int i);
    return cfg_image_out[8*i +: 8];
  endfunction

  function automatic logic [63:0] word(input logic [5:0] idx);
    logic [63:0] w;
    for (int b = 0; b < 7; b++) w[8*b +: 8] = {idx[3:0], 1'b0, b[2:0]};
    w[63:56] = (idx == 6'h01) ? 8'h00 : 8'h80;
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #5_000_000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    acc(1'b0, cdl_pkg::UPD_OFF, 8'h00);
    chk(ok, 1'b0, "access in lock");
    supply_ok_in <= 1'b1;
    repeat (30) @(posedge clock_in);
    chk(|cfg_image_out, 1'b0, "second side early");
    acc(1'b0, cdl_pkg::UPD_OFF, 8'h00);
    chk(ok, 1'b0, "access in download");
    for (n = 0; n < 5000 && boot_done_out !== 1'b1; n++)
      @(posedge clock_in);
    for (int i = 0; i < 224; i++)
      if (i < 'hD7 || i > 'hD9)
        chk(img(i), 8'h5A ^ i[7:0], "boot image");
    for (n = 0; n < 100 && nv_req_out !== 1'b1; n++) @(posedge clock_in);
    chk(n >= SE_W - 1 && n <= SE_W + 2, 1'b1, "fetch delay");
    for (n = 0; n < 200 && se_load_out !== 1'b1; n++) @(posedge clock_in);
    chk(se_word_out, word(6'h00), "first word");
    slow <= 1'b0;
    $display("test boot done");
    rdx(cdl_pkg::UPD_OFF, cdl_pkg::UPD_RESET);
    acc(1'b1, 16'h0010, 8'hA5);
    chk(img('h10), 8'hA5, "transparent");
    acc(1'b1, cdl_pkg::UPD_OFF, 8'h00);
    acc(1'b1, 16'h0010, 8'h3C);
    chk(img('h10), 8'hA5, "staged leak");
    rdx(16'h0010, 8'h3C);
    acc(1'b1, cdl_pkg::UPD_OFF, 8'h02);
    @(posedge clock_in);
    chk(img('h10), 8'h3C, "commit");
    rdx(cdl_pkg::UPD_OFF, 8'h00);
    $display("test update done");
    acc(1'b1, cdl_pkg::ERASE_OFF, 8'h00);
    rdx(16'hF800, 8'h5A);
    acc(1'b1, cdl_pkg::UPD_OFF, 8'h04);
    acc(1'b1, cdl_pkg::ERASE_OFF, 8'h00);
    rdx(16'hF800, 8'hFF);
    rdx(16'hF81F, 8'hFF);
    acc(1'b1, 16'hF810, 8'h77);
    chk(img('h10), 8'h3C, "nv write leak");
    acc(1'b1, cdl_pkg::RELOAD_OFF, 8'h01);
    for (n = 0; n < 400; n++) begin
      acc(1'b0, cdl_pkg::RELOAD_OFF, 8'h00);
      if (ok === 1'b1 && rd[0] === 1'b0) break;
    end
    chk(img('h10), 8'h77, "reload edit");
    chk(img('h00), 8'hFF, "reload erased");
    chk(img('h20), 8'h7A, "reload page 1");
    $display("test nv done");
    status_in <= '{10'h155, 10'h2AA, 8'h3C};
    @(posedge clock_in);
    rdx(cdl_pkg::UV_LO_OFF, 8'h55);
    rdx(cdl_pkg::UV_HI_OFF, 8'h01);
    rdx(cdl_pkg::OV_LO_OFF, 8'hAA);
    rdx(cdl_pkg::OV_HI_OFF, 8'h02);
    rdx(cdl_pkg::ADC_OFF, 8'h3C);
    status_in <= '{10'h2AA, 10'h155, 8'hC3};
    @(posedge clock_in);
    rdx(cdl_pkg::UV_LO_OFF, 8'hAA);
    rdx(cdl_pkg::ADC_OFF, 8'hC3);
    $display("test status done");
    pulse_fault(10'h208);
    rdx(cdl_pkg::FAULT_A_OFF, 8'h08);
    rdx(cdl_pkg::FAULT_B_OFF, 8'h02);
    repeat (20) @(posedge clock_in);
    rdx(cdl_pkg::FAULT_A_OFF, 8'h08);
    acc(1'b1, cdl_pkg::FAULT_A_OFF, 8'h08);
    rdx(cdl_pkg::FAULT_A_OFF, 8'h00);
    adv(6'h01);
    chk(se_word_out, word(6'h01), "fetch one");
    chk(se_idx_out, 6'h01, "index one");
    pulse_fault(10'h001);
    rdx(cdl_pkg::FAULT_A_OFF, 8'h00);
    adv(6'h3F);
    chk(se_idx_out, 6'h01, "reserved slot");
    adv(6'h02);
    chk(se_word_out, word(6'h02), "fetch two");
    pulse_fault(10'h001);
    rdx(cdl_pkg::FAULT_A_OFF, 8'h01);
    $display("test fault done");
    report_and_stop();
  end
endmodule
